// ---- rtl/rau_ripple_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// - full unit ripples one function over 8 bits, one lut per bit, dedicated carries.
// - half mode runs a 4-bit chain on the lower lut group.
// - first lut ripple input from fast, routed, constant one or constant zero.
// - each bit takes operands on inputs 1 and 0, gives result and carry.
// - top carry drives routed and fast outputs and four adjacent cells.
// - results and final carry optionally registered in unit flops, else bypass them; each pin still leaves through an output flop.
// - adder bits form propagate passing carry, generate supplying carry otherwise.
// - per-nibble add/sub select: 0 gives a plus b, 1 gives a minus b.
// - each adder result bit from one bit of each operand plus ripple bit.
// - counter feeds present count on input 0, loadable, result is count plus/minus one.
// - counter direction control 1 counts down, 0 counts up.
// - multiplier does 8x1 or 4x1 multiply-and-sum from control, input 1, input 0.
// - multiplier bit 1 adds multiplicand, 0 passes partial product unchanged.
// - wide multiplicand takes lower unit carry in, carry out holds multiply carry.
// - comparator carry out is 1 exactly when ge, le or ne holds.
// - wide compares cascade carry out to next carry in, lsb unit from config.
// - half mode upper four luts and flops are general logic; ninth flop holds carry.
//
module rau_ripple_unit (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// configuration
	input  wire rau_pkg::rau_cfg_s cfg,
	// operands and per-nibble controls
	input  wire rau_pkg::rau_operand_s lut_operand_inputs,
	input  wire logic              lower_nibble_control_in,
	input  wire logic              upper_nibble_control_in,
	// carry in
	input  wire logic              carry_in_routed,
	input  wire logic              carry_in_fast,
	// direct flop load
	input  wire logic              load_en,
	input  wire logic [7:0]        load_data,
	// upper nibble general logic in half mode
	input  wire logic [3:0]        upper_logic_in,
	// results
	output logic [7:0]             result,
	output logic [3:0]             upper_logic_out,
	// carry out
	output logic                   carry_out_routed,
	output logic                   carry_out_fast,
	output logic [3:0]             carry_out_adjacent
);

	// ---------------------------------------------------------------
	// per-bit lut function
	// ---------------------------------------------------------------
	// returns {propagate, generate} for one bit position
	function automatic logic [1:0] rau_bit_pg(
		input rau_pkg::rau_submode_e sub,
		input rau_pkg::rau_cmp_e     cmpf,
		input logic                  a,
		input logic                  b,
		input logic                  ctrl
	);
		logic bb;
		logic p;
		logic g;
		bb = 1'b0;
		p  = 1'b0;
		g  = 1'b0;
		case (sub)
			rau_pkg::RAU_SUB_ADDSUB: begin
				bb = b ^ ctrl;
				p  = a ^ bb;
				g  = a & bb;
			end
			rau_pkg::RAU_SUB_COUNT: begin
				// down adds all ones, up adds zero plus carry
				bb = ctrl;
				p  = a ^ bb;
				g  = a & bb;
			end
			rau_pkg::RAU_SUB_MULT: begin
				bb = b & ctrl;
				p  = a ^ bb;
				g  = a & bb;
			end
			rau_pkg::RAU_SUB_CMP: begin
				case (cmpf)
					rau_pkg::RAU_CMP_GE: begin
						p = ~(a ^ b);
						g = a & ~b;
					end
					rau_pkg::RAU_CMP_LE: begin
						p = ~(a ^ b);
						g = b & ~a;
					end
					rau_pkg::RAU_CMP_NE: begin
						p = ~(a ^ b);
						g = a ^ b;
					end
					default: begin
						p = 1'b0;
						g = 1'b0;
					end
				endcase
			end
			default: begin
				p = 1'b0;
				g = 1'b0;
			end
		endcase
		rau_bit_pg = {p, g};
	endfunction : rau_bit_pg

	// ---------------------------------------------------------------
	// first lut ripple input
	// ---------------------------------------------------------------
	// constant sources mark the least significant unit; there the
	// submode may need a fixed value, so it overrides the constant
	function automatic logic rau_first_carry(
		input rau_pkg::rau_cfg_s c,
		input logic              fast,
		input logic              routed,
		input logic              ctrl
	);
		logic sel;
		logic is_const;
		sel      = 1'b0;
		is_const = 1'b0;
		case (c.carry_src)
			rau_pkg::RAU_CIN_FAST: begin
				sel = fast;
			end
			rau_pkg::RAU_CIN_ROUTED: begin
				sel = routed;
			end
			rau_pkg::RAU_CIN_ONE: begin
				sel      = 1'b1;
				is_const = 1'b1;
			end
			rau_pkg::RAU_CIN_ZERO: begin
				sel      = 1'b0;
				is_const = 1'b1;
			end
			default: begin
				sel = 1'b0;
			end
		endcase
		if (is_const && c.submode == rau_pkg::RAU_SUB_ADDSUB && ctrl) begin
			sel = 1'b1;
		end
		if (is_const && c.submode == rau_pkg::RAU_SUB_COUNT) begin
			sel = ~ctrl;
		end
		rau_first_carry = sel;
	endfunction : rau_first_carry

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [7:0] unit_res_ff;
	logic [7:0] nxt_unit_res;
	logic       unit_carry_ff;
	logic       nxt_unit_carry;
	logic [7:0] result_ff;
	logic [7:0] nxt_result;
	logic [3:0] upper_ff;
	logic [3:0] nxt_upper;
	logic       carry_out_routed_routed_ff;
	logic       nxt_carry_out_routed_routed;
	logic       carry_out_routed_fast_ff;
	logic       nxt_carry_out_routed_fast;
	logic [3:0] adj_ff;
	logic [3:0] nxt_adj;

	// ---------------------------------------------------------------
	// carry chain
	// ---------------------------------------------------------------
	logic [7:0] op_a;
	logic [7:0] op_b;
	logic [7:0] bit_ctrl;
	logic [7:0] prop;
	logic [7:0] gen;
	logic [8:0] chain;
	logic [7:0] sum;
	logic       top_carry;

	// counter takes its present count from the unit flops
	assign op_a = (cfg.submode == rau_pkg::RAU_SUB_COUNT) ? unit_res_ff : lut_operand_inputs.kz0;
	assign op_b = lut_operand_inputs.kz1;

	assign chain[0] = rau_first_carry(cfg, carry_in_fast, carry_in_routed, lower_nibble_control_in);

	genvar gi;
	generate
		for (gi = 0; gi < rau_pkg::WIDTH; gi++) begin : g_bit
			logic [1:0] pg;
			assign bit_ctrl[gi] = (gi < rau_pkg::NIB) ? lower_nibble_control_in : upper_nibble_control_in;
			assign pg           = rau_bit_pg(cfg.submode, cfg.cmp_func, op_a[gi], op_b[gi], bit_ctrl[gi]);
			assign prop[gi]     = pg[1];
			assign gen[gi]      = pg[0];
			assign chain[gi+1]  = prop[gi] ? chain[gi] : gen[gi];
			assign sum[gi]      = prop[gi] ^ chain[gi];
		end
	endgenerate

	// half mode ends the chain at the lower nibble
	assign top_carry = cfg.half_mode ? chain[rau_pkg::NIB] : chain[rau_pkg::WIDTH];

	// ---------------------------------------------------------------
	// unit flops and ninth flop
	// ---------------------------------------------------------------
	always_comb begin
		nxt_unit_res   = {upper_logic_in, sum[3:0]};
		nxt_unit_carry = top_carry;
		if (!cfg.half_mode) begin
			nxt_unit_res = sum;
		end
		if (load_en) begin
			nxt_unit_res = load_data;
		end
		if (cfg.half_mode && load_en) begin
			nxt_unit_res = {upper_logic_in, load_data[3:0]};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			unit_res_ff   <= rau_pkg::RST_RESULT;
			unit_carry_ff <= rau_pkg::RST_CARRY;
		end else begin
			unit_res_ff   <= nxt_unit_res;
			unit_carry_ff <= nxt_unit_carry;
		end
	end

	// ---------------------------------------------------------------
	// output stage
	// ---------------------------------------------------------------
	// every pin leaves through a flop, so the combinational choice
	// still costs one cycle; registered costs two
	logic carry_sel;
	logic [7:0] res_sel;

	always_comb begin
		res_sel   = cfg.reg_result ? unit_res_ff : nxt_unit_res;
		carry_sel = cfg.reg_carry ? unit_carry_ff : top_carry;
		nxt_result = res_sel;
		nxt_upper  = rau_pkg::RST_UPPER;
		if (cfg.half_mode) begin
			nxt_result = {rau_pkg::RST_UPPER, res_sel[3:0]};
			nxt_upper  = res_sel[7:4];
		end
		nxt_carry_out_routed_routed = cfg.carry_out_routed_routed_en & carry_sel;
		nxt_carry_out_routed_fast   = cfg.carry_out_routed_fast_en & carry_sel;
		nxt_adj         = cfg.adj_en & {rau_pkg::ADJ_CELLS{carry_sel}};
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			result_ff      <= rau_pkg::RST_RESULT;
			upper_ff       <= rau_pkg::RST_UPPER;
			carry_out_routed_routed_ff <= rau_pkg::RST_CARRY;
			carry_out_routed_fast_ff   <= rau_pkg::RST_CARRY;
			adj_ff         <= rau_pkg::RST_ADJ;
		end else begin
			result_ff      <= nxt_result;
			upper_ff       <= nxt_upper;
			carry_out_routed_routed_ff <= nxt_carry_out_routed_routed;
			carry_out_routed_fast_ff   <= nxt_carry_out_routed_fast;
			adj_ff         <= nxt_adj;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// comparator true sense for lt, gt, eq is left to the reader of
	// the carry, which inverts it outside this unit
	assign result             = result_ff;
	assign upper_logic_out    = upper_ff;
	assign carry_out_routed   = carry_out_routed_routed_ff;
	assign carry_out_fast     = carry_out_routed_fast_ff;
	assign carry_out_adjacent = adj_ff;

endmodule : rau_ripple_unit
`default_nettype wire

// ---- rtl/rau_pkg.sv ----
package rau_pkg;

	// ---------------------------------------------------------------
	// widths and reset values
	// ---------------------------------------------------------------
	localparam int unsigned WIDTH      = 8;
	localparam int unsigned NIB        = 4;
	localparam int unsigned ADJ_CELLS  = 4;
	localparam logic [7:0]  RST_RESULT = 8'h00;
	localparam logic [3:0]  RST_UPPER  = 4'h0;
	localparam logic [3:0]  RST_ADJ    = 4'h0;
	localparam logic        RST_CARRY  = 1'b0;

	// ---------------------------------------------------------------
	// configuration encodings
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		RAU_SUB_ADDSUB = 2'h0,
		RAU_SUB_COUNT  = 2'h1,
		RAU_SUB_MULT   = 2'h2,
		RAU_SUB_CMP    = 2'h3
	} rau_submode_e;

	typedef enum logic [1:0] {
		RAU_CMP_GE = 2'h0,
		RAU_CMP_LE = 2'h1,
		RAU_CMP_NE = 2'h2
	} rau_cmp_e;

	typedef enum logic [1:0] {
		RAU_CIN_FAST   = 2'h0,
		RAU_CIN_ROUTED = 2'h1,
		RAU_CIN_ONE    = 2'h2,
		RAU_CIN_ZERO   = 2'h3
	} rau_cin_e;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic         half_mode;
		rau_submode_e submode;
		rau_cmp_e     cmp_func;
		rau_cin_e     carry_src;
		logic         reg_result;
		logic         reg_carry;
		logic         carry_out_routed_routed_en;
		logic         carry_out_routed_fast_en;
		logic [3:0]   adj_en;
	} rau_cfg_s;

	typedef struct packed {
		logic [7:0] kz1;
		logic [7:0] kz0;
	} rau_operand_s;

endpackage : rau_pkg

// ---- tb/rau_adj_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------
// lower neighbour unit driving the carry lines
// -------------------------------------------
module rau_adj_model (
	// which line the neighbour drives and its value
	input  wire logic [1:0] sel,
	input  wire logic       cval,
	// carry lines into the unit
	output logic            carry_in_fast,
	output logic            carry_in_routed
);
	// an idle line shows the inverse so a wrong pick never matches
	assign carry_in_fast   = (sel == 2'h0) ? cval : !cval;
	assign carry_in_routed = (sel == 2'h1) ? cval : !cval;
endmodule : rau_adj_model
`default_nettype wire

// ---- tb/rau_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------
// port checker
// ---------------------------
module rau_props (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// inputs
	input  wire rau_pkg::rau_cfg_s     cfg,
	input  wire rau_pkg::rau_operand_s lut_operand_inputs,
	input  wire logic                  lower_nibble_control_in,
	input  wire logic                  upper_nibble_control_in,
	input  wire logic                  load_en,
	// outputs
	input  wire logic [7:0]            result,
	input  wire logic                  carry_out_routed,
	input  wire logic [3:0]            carry_out_adjacent
);
	logic [7:0] a, b;
	logic       fl, ad, cz, lo, hi;
	assign a  = lut_operand_inputs.kz0;
	assign b  = lut_operand_inputs.kz1;
	assign lo = !lower_nibble_control_in && !upper_nibble_control_in;
	assign hi = lower_nibble_control_in && upper_nibble_control_in;
	// only one-flop paths, so each check looks one edge ahead
	assign fl = rst_n && !cfg.reg_result && !cfg.reg_carry && !load_en && cfg.carry_out_routed_routed_en;
	assign ad = fl && cfg.submode == rau_pkg::RAU_SUB_ADDSUB;
	assign cz = cfg.carry_src == rau_pkg::RAU_CIN_ZERO;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_ADD: assert property (ad && cz && lo && !cfg.half_mode |=> result == $past(a) + $past(b))
		else $error("sum wrong");
	AST_ONE: assert property (ad && cfg.carry_src == rau_pkg::RAU_CIN_ONE && lo && !cfg.half_mode
		|=> result == $past(a) + $past(b) + 8'h01) else $error("carry source one ignored");
	AST_SUB: assert property (ad && cz && hi && !cfg.half_mode
		|=> result == $past(a) - $past(b) && carry_out_routed == ($past(a) >= $past(b))) else $error("diff wrong");
	AST_HALF: assert property (ad && cz && lo && cfg.half_mode
		|=> result[7:4] == 4'h0 && result[3:0] == 4'($past(a) + $past(b))) else $error("half sum wrong");
	AST_MUL0: assert property (fl && cfg.submode == rau_pkg::RAU_SUB_MULT && cz && lo && !cfg.half_mode
		|=> result == $past(a) && !carry_out_routed) else $error("product not passed");
	AST_GE: assert property (fl && cfg.submode == rau_pkg::RAU_SUB_CMP && cfg.cmp_func == rau_pkg::RAU_CMP_GE
		&& cfg.carry_src == rau_pkg::RAU_CIN_ONE |=> carry_out_routed == ($past(a) >= $past(b)))
		else $error("ge wrong");
	AST_NE: assert property (fl && cfg.submode == rau_pkg::RAU_SUB_CMP && cfg.cmp_func == rau_pkg::RAU_CMP_NE
		&& cz |=> carry_out_routed == ($past(a) != $past(b))) else $error("ne wrong");
	AST_ADJ: assert property (fl |=> carry_out_adjacent == ($past(cfg.adj_en) & {4{carry_out_routed}}))
		else $error("adjacent carry wrong");
endmodule : rau_props
bind rau_ripple_unit rau_props chk_u (.clk(clk), .rst_n(rst_n), .cfg(cfg), .lut_operand_inputs(lut_operand_inputs),
	.lower_nibble_control_in(lower_nibble_control_in), .upper_nibble_control_in(upper_nibble_control_in),
	.load_en(load_en), .result(result), .carry_out_routed(carry_out_routed), .carry_out_adjacent(carry_out_adjacent));
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------------------------
// bench
// ---------------------------
module testbench;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	rau_pkg::rau_cfg_s     cfg = '0;
	rau_pkg::rau_operand_s ops = '0;
	logic                  c0 = 1'b0;
	logic                  ld = 1'b0;
	logic                  cv = 1'b0;
	logic [7:0]            ldd = 8'h00;
	logic [3:0]            uli = 4'h0;
	logic [7:0]            res;
	logic [3:0]            ulo, coa;
	logic                  cor, cof, cif, cir;
	int                    mismatches = 0;
	int                    compares = 0;
	logic [7:0]            va [4] = '{8'h03, 8'hFF, 8'h7F, 8'h05};
	logic [7:0]            vb [4] = '{8'h04, 8'h01, 8'h80, 8'h05};
	initial forever #50 clk = ~clk;
	rau_adj_model adj_u (.sel(cfg.carry_src), .cval(cv), .carry_in_fast(cif), .carry_in_routed(cir));
	rau_ripple_unit dut_u (.clk(clk), .rst_n(rst_n), .cfg(cfg), .lut_operand_inputs(ops),
		.lower_nibble_control_in(c0), .upper_nibble_control_in(c0), .carry_in_routed(cir),
		.carry_in_fast(cif), .load_en(ld), .load_data(ldd), .upper_logic_in(uli), .result(res),
		.upper_logic_out(ulo), .carry_out_routed(cor), .carry_out_fast(cof), .carry_out_adjacent(coa));
	task automatic chk(input logic [8:0] s, input logic [8:0] e, input string n);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : step
	task automatic setc(input logic [1:0] sm, input logic [1:0] cs);
		cfg = '0;
		cfg.submode = rau_pkg::rau_submode_e'(sm);
		cfg.carry_src = rau_pkg::rau_cin_e'(cs);
		cfg.carry_out_routed_routed_en = 1'b1;
		cfg.carry_out_routed_fast_en = 1'b1;
		cfg.adj_en = 4'hF;
	endtask : setc
	task automatic op(input logic [7:0] a, input logic [7:0] b, input logic c);
		ops.kz0 = a;
		ops.kz1 = b;
		c0 = c;
		step(1);
	endtask : op
	task automatic t_arith();
		logic [7:0] bb;
		logic       ci;
		for (int s = 0; s < 4; s++)
			for (int k = 0; k < 8; k++) begin
				setc(2'h0, s[1:0]);
				cv = k[0];
				bb = k[2] ? ~vb[k%4] : vb[k%4];
				ci = (s > 1) ? (s == 2 || k[2]) : cv;
				op(va[k%4], vb[k%4], k[2]);
				chk({cor, res}, {1'b0, va[k%4]} + bb + ci, "sum");
				chk({cof, coa}, {5{cor}}, "carry fanout");
			end
		$display("arith done");
	endtask : t_arith
	task automatic t_half();
		setc(2'h0, 2'h3);
		cfg.half_mode = 1'b1;
		uli = 4'hA;
		op(8'hA9, 8'hB8, 1'b0);
		chk({cor, res}, 9'h101, "half sum");
		step(1);
		chk(ulo, 4'hA, "upper logic");
		$display("half done");
	endtask : t_half
	task automatic t_mult();
		for (int k = 0; k < 8; k++) begin
			setc(2'h2, k[0] ? 2'h0 : 2'h3);
			cv = 1'b1;
			op(va[k%4], vb[k%4], k[2]);
			chk({cor, res}, {1'b0, va[k%4]} + (k[2] ? vb[k%4] : 8'h00) + k[0], "mac");
		end
		$display("mult done");
	endtask : t_mult
	task automatic t_cmp();
		logic e;
		for (int f = 0; f < 4; f++)
			for (int k = 0; k < 4; k++) begin
				setc(2'h3, f == 2 ? 2'h3 : (f == 3 ? 2'h0 : 2'h2));
				cfg.cmp_func = rau_pkg::rau_cmp_e'(f == 3 ? 0 : f);
				cv = k[0];
				e = f == 0 ? va[k] >= vb[k] : f == 1 ? va[k] <= vb[k] : f == 2 ? va[k] != vb[k]
					: (va[k] > vb[k]) | (va[k] == vb[k] & cv);
				op(va[k], vb[k], 1'b0);
				chk(cor, e, "compare");
				if (f == 0) chk(!cor, va[k] < vb[k], "less");
			end
		$display("cmp done");
	endtask : t_cmp
	task automatic t_count();
		for (int d = 0; d < 2; d++) begin
			setc(2'h1, 2'h3);
			ops.kz0 = 8'h5A;
			ldd = d ? 8'h01 : 8'hFF;
			ld = 1'b1;
			c0 = d[0];
			step(1);
			ld = 1'b0;
			for (int i = 0; i < 4 && res !== ldd; i++) step(1);
			chk(res, ldd, "load");
			step(1);
			chk(res, 9'h000, "wrap");
			step(1);
			chk(res, d ? 9'h0FF : 9'h001, "count");
		end
		$display("count done");
	endtask : t_count
	task automatic t_reg();
		setc(2'h0, 2'h3);
		cfg.reg_result = 1'b1;
		cfg.reg_carry = 1'b1;
		op(8'h00, 8'h00, 1'b0);
		step(2);
		op(8'hFF, 8'h01, 1'b0);
		chk({cor, res}, 9'h000, "early");
		op(8'h00, 8'h00, 1'b0);
		chk({cor, res}, 9'h100, "piped");
		// routed line off, two of four neighbours fed
		cfg.carry_out_routed_routed_en = 1'b0;
		cfg.adj_en = 4'h5;
		op(8'hFF, 8'h01, 1'b0);
		step(2);
		chk({cor, cof, coa}, 9'h015, "gated");
		$display("reg done");
	endtask : t_reg
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop
	initial begin
		step(4);
		rst_n = 1'b1;
		step(1);
		t_arith();
		t_half();
		t_mult();
		t_cmp();
		t_count();
		t_reg();
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
